// [src/tpi_cfg.svh]
`ifndef TPI_CFG_SVH
`define TPI_CFG_SVH

// Register offsets on the serial register port
`define TPI_ADDR_BOOST 8'h1f
`define TPI_ADDR_TUNE 8'h20
`define TPI_ADDR_SPARE 8'h21
`define TPI_ADDR_MASK 8'h22
`define TPI_ADDR_SRC 8'h23
`define TPI_ADDR_STAT 8'h24

// Reset values
`define TPI_RST_BOOST 8'h00
`define TPI_RST_TUNE 8'h01
`define TPI_RST_SPARE 8'h00
`define TPI_RST_MASK 8'h08

// Source flag and mask bit positions
`define TPI_SRC_MOTOR_SHORT 7
`define TPI_SRC_OBJECT_NEAR 6
`define TPI_SRC_OBJECT_AWAY 5
`define TPI_SRC_CALIB_DONE 4
`define TPI_SRC_STYLUS_DOWN 3
`define TPI_SRC_STYLUS_UP 2
`define TPI_SRC_HEAT_WARN 1
`define TPI_SRC_HEAT_ALARM 0

// Status bit positions
`define TPI_STAT_MOTOR_SHORT 7
`define TPI_STAT_RESET_SEEN 6
`define TPI_STAT_OBJECT_NEAR 5
`define TPI_STAT_CALIB 4
`define TPI_STAT_CONV 3
`define TPI_STAT_STYLUS 2
`define TPI_STAT_HEAT_WARN 1
`define TPI_STAT_HEAT_ALARM 0

// Boost field
`define TPI_BOOST_MSB 5
`define TPI_BOOST_LSB 3

`endif

// [src/tpi_evt_if.sv]
`timescale 1ns/10ps
interface tpi_evt_if;
  logic motor_short;
  logic object_near;
  logic calib_pending;
  logic conv_running;
  logic conv_is_prox;
  logic stylus_down;
  logic heat_warn;
  logic heat_alarm;
  logic near_flag_select;
  logic stylus_detect_mode;
  logic heat_warn_edge_select;
  logic heat_alarm_edge_select;
  logic src_read;
  logic [7:0] flags;

  modport cap (
    input motor_short, object_near, calib_pending, conv_running, conv_is_prox,
    input stylus_down, heat_warn, heat_alarm, near_flag_select, stylus_detect_mode,
    input heat_warn_edge_select, heat_alarm_edge_select, src_read,
    output flags
  );

  modport top (
    output motor_short, object_near, calib_pending, conv_running, conv_is_prox,
    output stylus_down, heat_warn, heat_alarm, near_flag_select, stylus_detect_mode,
    output heat_warn_edge_select, heat_alarm_edge_select, src_read,
    input flags
  );
endinterface : tpi_evt_if

// [src/tpi_irq_status.sv]
`timescale 1ns/10ps
`include "tpi_cfg.svh"
// Operation
// [R1] One enable bit per source; after reset only bit 3 is enabled.
// [R2] Flag bit 7 sets on motor short status rising edge.
// [R3] Flag bit 6 sets on object near status rising edge.
// [R4] Flag bit 5: object away edge, or proximity conversion end, per select.
// [R5] Flag bit 4 sets when calibration pending status falls.
// [R6] Flag bit 3: stylus down edge in detect mode, else touch conversion end.
// [R7] Flag bit 2 sets on stylus down status falling edge.
// [R8] Flag bit 1 sets on chosen edge of heat warning status.
// [R9] Flag bit 0 sets on chosen edge of heat alarm status.
// [R10] Status bit 7 shows motor short live.
// [R11] Status bit 6 latches after reset, cleared by any status read.
// [R12] Status bit 5 shows object near live, zero when far or disabled.
// [R13] Near status and average freeze while the stylus is down.
// [R14] Near status keeps updating while the motor runs.
// [R15] Status bit 4 reads pending calibration; writing 1 schedules one.
// [R16] Status bit 3 shows a conversion running.
// [R17] Status bit 2 shows stylus down live.
// [R18] Status bit 1 shows heat above warning threshold.
// [R19] Status bit 0 shows heat above alarm threshold.
// [R20] Host writes boost field 100 or 110 and 100 into bits 2:0.
// [R21] Host writes 0x81 into the tuning register after boost.
// [R22] Flags stay set until source read; interrupt while any enabled flag set.
module tpi_irq_status (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire tpi_pkg::tpi_byte_t reg_addr_i,
  input wire tpi_pkg::tpi_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output tpi_pkg::tpi_byte_t reg_rdata_o,
  output logic irq_o,
  input wire logic motor_short_live_i,
  input wire logic object_near_raw_i,
  input wire tpi_pkg::tpi_avg_t near_average_in_i,
  input wire logic calib_busy_i,
  input wire logic conversion_running_live_i,
  input wire logic conversion_is_prox_i,
  input wire logic stylus_down_live_i,
  input wire logic heat_warn_live_i,
  input wire logic heat_alarm_live_i,
  input wire logic near_flag_select_i,
  input wire logic stylus_detect_mode_i,
  input wire logic heat_warn_edge_select_i,
  input wire logic heat_alarm_edge_select_i,
  output tpi_pkg::tpi_avg_t near_average_value_o,
  output logic [2:0] near_gain_raise_o,
  output tpi_pkg::tpi_byte_t proximity_boost_config_o,
  output tpi_pkg::tpi_byte_t proximity_tuning_fixed_o,
  output logic calib_request_o
);
  import tpi_pkg::*;

  tpi_top_s r;
  tpi_top_s next_r;
  tpi_byte_t live_status;
  logic calib_pending_live;
  logic wr_hit_boost;
  logic wr_hit_tune;
  logic wr_hit_mask;
  logic wr_hit_stat;
  logic rd_hit_src;
  logic rd_hit_stat;

  tpi_evt_if evt ();

  function automatic logic hit(input tpi_byte_t addr, input tpi_byte_t want, input logic strobe);
    hit = strobe && (addr == want);
  endfunction : hit

  assign wr_hit_boost = hit(reg_addr_i, `TPI_ADDR_BOOST, reg_wr_i);
  assign wr_hit_tune = hit(reg_addr_i, `TPI_ADDR_TUNE, reg_wr_i);
  assign wr_hit_mask = hit(reg_addr_i, `TPI_ADDR_MASK, reg_wr_i);
  assign wr_hit_stat = hit(reg_addr_i, `TPI_ADDR_STAT, reg_wr_i);
  assign rd_hit_src = hit(reg_addr_i, `TPI_ADDR_SRC, reg_rd_i);
  assign rd_hit_stat = hit(reg_addr_i, `TPI_ADDR_STAT, reg_rd_i);

  // Pending covers both the wait for the engine and the run itself
  assign calib_pending_live = (r.cal != TPI_CAL_IDLE); // R15

  always_comb begin
    live_status = 8'h00;
    live_status[`TPI_STAT_MOTOR_SHORT] = motor_short_live_i; // R10
    live_status[`TPI_STAT_RESET_SEEN] = r.reset_seen; // R11
    live_status[`TPI_STAT_OBJECT_NEAR] = r.object_near; // R12
    live_status[`TPI_STAT_CALIB] = calib_pending_live; // R15
    live_status[`TPI_STAT_CONV] = conversion_running_live_i; // R16
    live_status[`TPI_STAT_STYLUS] = stylus_down_live_i; // R17
    live_status[`TPI_STAT_HEAT_WARN] = heat_warn_live_i; // R18
    live_status[`TPI_STAT_HEAT_ALARM] = heat_alarm_live_i; // R19
  end

  assign evt.motor_short = motor_short_live_i;
  assign evt.object_near = r.object_near;
  assign evt.calib_pending = calib_pending_live;
  assign evt.conv_running = conversion_running_live_i;
  assign evt.conv_is_prox = conversion_is_prox_i;
  assign evt.stylus_down = stylus_down_live_i;
  assign evt.heat_warn = heat_warn_live_i;
  assign evt.heat_alarm = heat_alarm_live_i;
  assign evt.near_flag_select = near_flag_select_i;
  assign evt.stylus_detect_mode = stylus_detect_mode_i;
  assign evt.heat_warn_edge_select = heat_warn_edge_select_i;
  assign evt.heat_alarm_edge_select = heat_alarm_edge_select_i;
  assign evt.src_read = rd_hit_src; // R22

  tpi_src_capture u_capture (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .evt(evt)
  );

  always_comb begin
    next_r = r;
    next_r.cal_req = 1'b0;

    // Register writes; the spare register and read-only bits ignore writes
    if (wr_hit_boost) begin
      next_r.boost = reg_wdata_i;
    end
    if (wr_hit_tune) begin
      next_r.tune = reg_wdata_i;
    end
    if (wr_hit_mask) begin
      next_r.mask = reg_wdata_i; // R1
    end

    // Only a read clears it; the reset itself is what sets it
    if (rd_hit_stat) begin
      next_r.reset_seen = 1'b0; // R11
    end

    // Haptics activity plays no part here, only the stylus freezes the value
    if (!stylus_down_live_i) begin
      next_r.object_near = object_near_raw_i; // R13 R14
      next_r.near_avg = near_average_in_i; // R13
    end

    unique case (r.cal)
      TPI_CAL_IDLE: begin
        if (wr_hit_stat && reg_wdata_i[`TPI_STAT_CALIB]) begin
          next_r.cal = TPI_CAL_WAIT; // R15
          next_r.cal_req = 1'b1; // R15
        end
      end
      TPI_CAL_WAIT: begin
        // A second request while one is queued merges into it
        if (calib_busy_i) begin
          next_r.cal = TPI_CAL_RUN;
        end
      end
      TPI_CAL_RUN: begin
        if (!calib_busy_i) begin
          next_r.cal = TPI_CAL_IDLE; // R15
        end
      end
    endcase

    // Read data registered one cycle after the strobe; unmapped reads give zero
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `TPI_ADDR_BOOST: next_r.rdata = r.boost;
        `TPI_ADDR_TUNE: next_r.rdata = r.tune;
        `TPI_ADDR_SPARE: next_r.rdata = `TPI_RST_SPARE;
        `TPI_ADDR_MASK: next_r.rdata = r.mask;
        `TPI_ADDR_SRC: next_r.rdata = evt.flags;
        `TPI_ADDR_STAT: next_r.rdata = live_status;
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r.boost <= `TPI_RST_BOOST;
      r.tune <= `TPI_RST_TUNE;
      r.mask <= `TPI_RST_MASK; // R1
      r.reset_seen <= 1'b1; // R11
      r.object_near <= 1'b0;
      r.near_avg <= 12'h000;
      r.cal <= TPI_CAL_IDLE;
      r.cal_req <= 1'b0;
      r.rdata <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  // Boost codes are not checked; the host owns the legal values
  assign near_gain_raise_o = r.boost[`TPI_BOOST_MSB:`TPI_BOOST_LSB]; // R20
  assign proximity_boost_config_o = r.boost; // R20
  assign proximity_tuning_fixed_o = r.tune; // R21
  assign near_average_value_o = r.near_avg; // R13
  assign calib_request_o = r.cal_req; // R15
  assign reg_rdata_o = r.rdata;
  assign irq_o = |(evt.flags & r.mask); // R22

endmodule : tpi_irq_status

// [src/tpi_pkg.sv]
package tpi_pkg;

  typedef logic [7:0] tpi_byte_t;
  typedef logic [11:0] tpi_avg_t;

  typedef enum logic [1:0] {
    TPI_CAL_IDLE,
    TPI_CAL_WAIT,
    TPI_CAL_RUN
  } tpi_cal_e;

  typedef struct packed {
    tpi_byte_t boost;
    tpi_byte_t tune;
    tpi_byte_t mask;
    logic reset_seen;
    logic object_near;
    tpi_avg_t near_avg;
    tpi_cal_e cal;
    logic cal_req;
    tpi_byte_t rdata;
  } tpi_top_s;

  typedef struct packed {
    logic motor_short;
    logic object_near;
    logic calib_pending;
    logic conv_running;
    logic conv_kind_prox;
    logic stylus_down;
    logic heat_warn;
    logic heat_alarm;
    tpi_byte_t flags;
  } tpi_cap_s;

endpackage : tpi_pkg

// [src/tpi_src_capture.sv]
`timescale 1ns/10ps
`include "tpi_cfg.svh"
module tpi_src_capture (
  input wire logic mclk_i,
  input wire logic rst_i,
  tpi_evt_if.cap evt
);
  import tpi_pkg::*;

  tpi_cap_s r;
  tpi_cap_s next_r;

  // Selected edge of a level: 0 picks rising, 1 picks falling
  function automatic logic edge_seen(input logic prev, input logic cur, input logic fall);
    edge_seen = fall ? (prev & ~cur) : (~prev & cur);
  endfunction : edge_seen

  always_comb begin
    logic [7:0] set;
    set = 8'h00;
    set[`TPI_SRC_MOTOR_SHORT] = edge_seen(r.motor_short, evt.motor_short, 1'b0); // R2
    set[`TPI_SRC_OBJECT_NEAR] = edge_seen(r.object_near, evt.object_near, 1'b0); // R3
    if (evt.near_flag_select) begin
      // Conversion end counts only when the finished conversion was a proximity one
      set[`TPI_SRC_OBJECT_AWAY] = edge_seen(r.conv_running, evt.conv_running, 1'b1)
        & r.conv_kind_prox; // R4
    end else begin
      set[`TPI_SRC_OBJECT_AWAY] = edge_seen(r.object_near, evt.object_near, 1'b1); // R4
    end
    set[`TPI_SRC_CALIB_DONE] = edge_seen(r.calib_pending, evt.calib_pending, 1'b1); // R5
    if (evt.stylus_detect_mode) begin
      set[`TPI_SRC_STYLUS_DOWN] = edge_seen(r.stylus_down, evt.stylus_down, 1'b0); // R6
    end else begin
      set[`TPI_SRC_STYLUS_DOWN] = edge_seen(r.conv_running, evt.conv_running, 1'b1)
        & ~r.conv_kind_prox; // R6
    end
    set[`TPI_SRC_STYLUS_UP] = edge_seen(r.stylus_down, evt.stylus_down, 1'b1); // R7
    set[`TPI_SRC_HEAT_WARN] = edge_seen(r.heat_warn, evt.heat_warn,
      evt.heat_warn_edge_select); // R8
    set[`TPI_SRC_HEAT_ALARM] = edge_seen(r.heat_alarm, evt.heat_alarm,
      evt.heat_alarm_edge_select); // R9
    next_r = r;
    next_r.motor_short = evt.motor_short;
    next_r.object_near = evt.object_near;
    next_r.calib_pending = evt.calib_pending;
    next_r.conv_running = evt.conv_running;
    next_r.stylus_down = evt.stylus_down;
    next_r.heat_warn = evt.heat_warn;
    next_r.heat_alarm = evt.heat_alarm;
    // Kind is held after the conversion ends so its falling edge can be classified
    if (evt.conv_running) begin
      next_r.conv_kind_prox = evt.conv_is_prox;
    end
    // A new event in the read cycle survives the clear
    next_r.flags = (r.flags & ~{8{evt.src_read}}) | set; // R22
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign evt.flags = r.flags;

endmodule : tpi_src_capture

// [test/tb.sv]
`timescale 1ns/10ps
module tb;
  import tpi_pkg::*;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic reg_wr_i = 1'h0, reg_rd_i = 1'h0, irq_o, creq, busy, conv = 1'h0, kind = 1'h0;
  logic pend = 1'h0, rseen = 1'h1, near_q = 1'h0;
  logic [4:0] lv = 5'h0;
  logic [3:0] sel = 4'h0, lag = 4'h0;
  logic [2:0] gain;
  tpi_byte_t reg_addr_i = 8'h0, reg_wdata_i = 8'h0, reg_rdata_o, c_boost, c_tune;
  tpi_byte_t m_boost = 8'h0, m_tune = 8'h1, m_mask = 8'h8, m_flags = 8'h0;
  tpi_byte_t tbl [8] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h24, 8'h30};
  tpi_avg_t avg_in = 12'h0, avg_out, avg_q = 12'h0;
  integer seed = 32'h02c18c3c, failures = 0, n_compared = 0, i, j, k;
  always #12.5 mclk_i = ~mclk_i;
  tpi_irq_status dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .motor_short_live_i(lv[4]), .object_near_raw_i(lv[3]), .near_average_in_i(avg_in),
    .calib_busy_i(busy), .conversion_running_live_i(conv), .conversion_is_prox_i(kind),
    .stylus_down_live_i(lv[2]), .heat_warn_live_i(lv[1]), .heat_alarm_live_i(lv[0]),
    .near_flag_select_i(sel[0]), .stylus_detect_mode_i(sel[1]),
    .heat_warn_edge_select_i(sel[2]), .heat_alarm_edge_select_i(sel[3]),
    .near_average_value_o(avg_out), .near_gain_raise_o(gain),
    .proximity_boost_config_o(c_boost), .proximity_tuning_fixed_o(c_tune),
    .calib_request_o(creq));
  tpi_calib_engine eng (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(creq), .lag_i(lag), .busy_o(busy));
  task chk(input tpi_byte_t seen, input tpi_byte_t want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk
  task report_and_stop;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : cyc
  task wr(input tpi_byte_t a, input tpi_byte_t d);
    cyc(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    cyc(1);
    reg_wr_i = 1'h0;
    case (a)
      8'h1f: m_boost = d;
      8'h20: m_tune = d;
      8'h22: m_mask = d;
      8'h24: pend = pend | d[4];
      default: ;
    endcase
  endtask : wr
  task rd(input tpi_byte_t a);
    tpi_byte_t e;
    case (a)
      8'h1f: e = m_boost;
      8'h20: e = m_tune;
      8'h22: e = m_mask;
      8'h23: e = m_flags;
      8'h24: e = {lv[4], rseen, near_q, pend, conv, lv[2:0]};
      default: e = 8'h0;
    endcase
    cyc(1);
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    cyc(1);
    reg_rd_i = 1'h0;
    chk(reg_rdata_o, e);
    if (a == 8'h23) m_flags = 8'h0;
    if (a == 8'h24) rseen = 1'h0;
    chk({7'h0, irq_o}, {7'h0, |(m_flags & m_mask)});
  endtask : rd
  task stim(input logic [4:0] v, input logic [3:0] s);
    logic [4:0] r;
    logic [4:0] f;
    logic nn;
    r = v & ~lv;
    f = ~v & lv;
    // Stylus down freezes near status, so the model holds it too
    nn = v[2] ? near_q : v[3];
    m_flags = m_flags | {r[4], nn & !near_q, !s[0] & !nn & near_q, 1'h0,
      s[1] & r[2], f[2], s[2] ? f[1] : r[1], s[3] ? f[0] : r[0]};
    near_q = nn;
    lv = v;
    sel = s;
    avg_in = 12'($random(seed));
    if (!v[2]) avg_q = avg_in;
    cyc(3);
    chk(avg_out[7:0], avg_q[7:0]);
    chk({4'h0, avg_out[11:8]}, {4'h0, avg_q[11:8]});
    chk({7'h0, irq_o}, {7'h0, |(m_flags & m_mask)});
  endtask : stim
  task run_conv(input logic p);
    conv = 1'h1;
    kind = p;
    rd(8'h24);
    conv = 1'h0;
    m_flags = m_flags | {2'h0, sel[0] & p, 1'h0, !sel[1] & !p, 3'h0};
    cyc(3);
  endtask : run_conv
  task calib(input logic [3:0] l);
    lag = l;
    wr(8'h24, 8'h10);
    chk({7'h0, creq}, 8'h01);
    rd(8'h24);
    chk({7'h0, creq}, 8'h00);
    // A second request while one is pending must not schedule another
    wr(8'h24, 8'h10);
    chk({7'h0, creq}, 8'h00);
    for (k = 0; k < 40 && !busy; k++) cyc(1);
    for (j = 0; j < 40 && busy; j++) cyc(1);
    if (k == 40 || j == 40) begin
      failures++;
      report_and_stop;
    end
    pend = 1'h0;
    m_flags[4] = 1'h1;
    cyc(3);
    rd(8'h23);
  endtask : calib
  initial begin
    cyc(6);
    rst_i = 1'h0;
    for (i = 0; i < 8; i++) rd(tbl[i]);
    wr(8'h1f, 8'h24);
    chk({5'h0, gain}, 8'h04);
    wr(8'h1f, 8'h34);
    wr(8'h20, 8'h81);
    chk({5'h0, gain}, 8'h06);
    chk(c_tune, 8'h81);
    chk(c_boost, 8'h34);
    wr(8'h21, 8'h5a);
    wr(8'h23, 8'hff);
    for (i = 0; i < 5; i++) rd(tbl[i]);
    for (i = 0; i < 48; i++) begin
      if (i % 8 == 0) wr(8'h22, 8'($random(seed)));
      stim(5'($random(seed)), 4'($random(seed)) & 4'he);
      if (i % 3 == 0) rd(8'h24);
      if (i % 4 == 3) rd(8'h23);
    end
    for (i = 0; i < 4; i++) begin
      stim(lv, {sel[3:2], i[1:0]});
      run_conv(1'h0);
      run_conv(1'h1);
      rd(8'h23);
    end
    wr(8'h22, 8'hff);
    rd(8'h22);
    calib(4'h0);
    calib(4'h9);
    rd(8'h24);
    report_and_stop;
  end
endmodule : tb

// [test/tpi_calib_engine.sv]
`timescale 1ns/10ps
module tpi_calib_engine (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [3:0] lag_i,
  output logic busy_o
);
  // Variable lag lets the bench try prompt and slow engines
  logic [1:0] st;
  logic [3:0] cnt;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      st <= 2'h0;
      busy_o <= 1'h0;
      cnt <= 4'h0;
    end else if (req_i && st == 2'h0) begin
      st <= 2'h1;
      cnt <= lag_i;
    end else if (st != 2'h0 && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (st == 2'h1) begin
      st <= 2'h2;
      busy_o <= 1'h1;
      cnt <= 4'h4;
    end else if (st == 2'h2) begin
      st <= 2'h0;
      busy_o <= 1'h0;
    end
  end
endmodule : tpi_calib_engine

// [test/tpi_irq_status_sva.sv]
`timescale 1ns/10ps
module tpi_irq_status_sva (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire tpi_pkg::tpi_byte_t reg_addr_i,
  input wire tpi_pkg::tpi_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire tpi_pkg::tpi_byte_t reg_rdata_o,
  input wire logic motor_short_live_i,
  input wire logic conversion_running_live_i,
  input wire logic stylus_down_live_i,
  input wire logic heat_warn_live_i,
  input wire logic heat_alarm_live_i,
  input wire tpi_pkg::tpi_avg_t near_average_value_o,
  input wire logic calib_request_o
);
  import tpi_pkg::*;
  logic wr_cal;
  assign wr_cal = reg_wr_i && reg_addr_i == 8'h24 && reg_wdata_i[4];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence st_rd; reg_rd_i && reg_addr_i == 8'h24; endsequence
  sequence mk_wr; reg_wr_i && reg_addr_i == 8'h22; endsequence
  sequence mk_rd; reg_rd_i && reg_addr_i == 8'h22; endsequence
  short_live_a: assert property (st_rd |=> reg_rdata_o[7] == $past(motor_short_live_i))
    else $error("short status wrong");
  stylus_live_a: assert property (st_rd |=> reg_rdata_o[2] == $past(stylus_down_live_i))
    else $error("stylus status wrong");
  conv_live_a: assert property (st_rd |=> reg_rdata_o[3] == $past(conversion_running_live_i))
    else $error("conversion status wrong");
  heat_live_a: assert property (st_rd |=> reg_rdata_o[1:0] ==
    {$past(heat_warn_live_i), $past(heat_alarm_live_i)}) else $error("heat status wrong");
  reset_clear_a: assert property (st_rd ##2 st_rd |=> !reg_rdata_o[6])
    else $error("reset flag not cleared");
  mask_rw_a: assert property (mk_wr ##2 mk_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("mask readback wrong");
  avg_hold_a: assert property (stylus_down_live_i |=> $stable(near_average_value_o))
    else $error("average moved while stylus down");
  calib_cause_a: assert property (calib_request_o |-> $past(wr_cal))
    else $error("calibration request without write");
endmodule : tpi_irq_status_sva
bind tpi_irq_status tpi_irq_status_sva u_sva (
  .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .motor_short_live_i(motor_short_live_i),
  .conversion_running_live_i(conversion_running_live_i),
  .stylus_down_live_i(stylus_down_live_i), .heat_warn_live_i(heat_warn_live_i),
  .heat_alarm_live_i(heat_alarm_live_i), .near_average_value_o(near_average_value_o),
  .calib_request_o(calib_request_o));
